// File: dsi_pkg.sv
// dsi_pkg: constants and carriers for the dual-section serial control slave
// assumes: one package shared by the slave core and its register-bank helper
package dsi_pkg;
  // fixed upper part of the 7-bit slave address
  localparam logic [4:0] ADDR_FIXED   = 5'h02;
  localparam int         ADDR_W       = 7;
  localparam int         BYTE_W       = 8;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // write-mode field positions
  localparam int WB_LIMIT_STYLE  = 7;
  localparam int WB_TONE_OUT_EN  = 6;
  localparam int WB_TONE_EN      = 5;
  localparam int WB_BOOST        = 4;
  localparam int WB_LEVEL        = 3;
  localparam int WB_ENABLE       = 2;
  localparam int WB_THRESH_TEST  = 1;
  localparam int WB_AUX          = 0;
  // read-mode field positions
  localparam int RB_MIN_CURRENT  = 7;
  localparam int RB_VOLTAGE      = 6;
  localparam int RB_TONE         = 5;
  localparam int RB_OVERTEMP     = 1;
  localparam int RB_OVERLOAD     = 0;
  // output level codes
  localparam logic [2:0] LVL_OFF  = 3'h0;
  localparam logic [2:0] LVL_13V4 = 3'h1;
  localparam logic [2:0] LVL_18V5 = 3'h2;
  localparam logic [2:0] LVL_14V4 = 3'h3;
  localparam logic [2:0] LVL_19V5 = 3'h4;
  localparam logic [2:0] LVL_22V  = 3'h5;

  typedef enum logic [1:0] {DSI_SEC_A, DSI_SEC_B} dsi_sec_e;

  // per-section analog status inputs
  typedef struct packed {
    logic min_current_flag;
    logic voltage_flag;
    logic tone_flag;
    logic overtemp_flag;
    logic overload_flag;
  } dsi_diag_s;

  // per-section control outputs
  typedef struct packed {
    logic       power_on;
    logic [2:0] level;
    logic       static_limit;
    logic       thresh_12ma;
    logic       tone_active;
    logic       tone_output_stage;
    logic       receive_output;
  } dsi_ctrl_s;
endpackage

// File: dsi_section.sv
// dsi_section: one section register plus its control decode
// assumes: write strobe and data come from the slave core on clk_i
`timescale 1ns/1ns
module dsi_section
  import dsi_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic            lockout_i,
  input  wire logic            wr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            tone_in_i,
  input  wire dsi_pkg::dsi_diag_s diag_i,
  output logic [7:0]           rdata_o,
  output dsi_pkg::dsi_ctrl_s   ctrl_o
);
  import dsi_pkg::*;
  logic [7:0] section_register;
  // analog status flags cross in through two flops
  dsi_diag_s  diag_meta;
  dsi_diag_s  diag_sync;
  logic [7:0] next_section_register;
  dsi_ctrl_s  next_ctrl;
  logic [7:0] next_rdata;

  always_comb
  begin
    next_section_register = section_register;
    if (lockout_i)
      next_section_register = REG_RESET;
    else if (wr_i)
      next_section_register = wdata_i;
  end

  always_comb
  begin
    logic en;
    en = section_register[WB_ENABLE];
    next_ctrl = '0;
    next_ctrl.receive_output = en;
    if (en)
    begin
      next_ctrl.power_on     = ~diag_sync.overtemp_flag;
      next_ctrl.static_limit = section_register[WB_LIMIT_STYLE];
      next_ctrl.thresh_12ma  = section_register[WB_THRESH_TEST];
      next_ctrl.tone_output_stage = section_register[WB_TONE_OUT_EN];
      if (section_register[WB_TONE_OUT_EN])
        next_ctrl.tone_active = section_register[WB_TONE_EN] | tone_in_i;
      if (section_register[WB_AUX])
        next_ctrl.level = LVL_22V;
      else
        unique case ({section_register[WB_BOOST], section_register[WB_LEVEL]})
          2'b00: next_ctrl.level = LVL_13V4;
          2'b01: next_ctrl.level = LVL_18V5;
          2'b10: next_ctrl.level = LVL_14V4;
          2'b11: next_ctrl.level = LVL_19V5;
        endcase
    end
    // otherwise all power controls stay inactive
    next_rdata = {diag_sync.min_current_flag, diag_sync.voltage_flag, diag_sync.tone_flag,
                  section_register[WB_BOOST:WB_ENABLE],
                  diag_sync.overtemp_flag, diag_sync.overload_flag};
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      section_register <= REG_RESET;
      ctrl_o           <= '0;
      rdata_o          <= REG_RESET;
      diag_meta        <= '0;
      diag_sync        <= '0;
    end
    else if (ce_i)
    begin
      section_register <= next_section_register;
      ctrl_o           <= next_ctrl;
      rdata_o          <= next_rdata;
      diag_meta        <= diag_i;
      diag_sync        <= diag_meta;
    end
  end

  property p_en_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !next_section_register[WB_ENABLE] && !section_register[WB_ENABLE]
        |=> !ctrl_o.power_on && ctrl_o.level == LVL_OFF;
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled section drives power");

  property p_write;
    @(posedge clk_i) disable iff (!rst_n_i) ce_i && wr_i && !lockout_i
      |=> section_register == $past(wdata_i);
  endproperty
  a_write: assert property (p_write) else $error("section write lost");

  property p_lock_clears;
    @(posedge clk_i) disable iff (!rst_n_i) ce_i && lockout_i |=> section_register == REG_RESET;
  endproperty
  a_lock_clears: assert property (p_lock_clears) else $error("register kept in lockout");

  property p_echo;
    @(posedge clk_i) disable iff (!rst_n_i) ce_i
      |=> rdata_o[WB_BOOST:WB_ENABLE] == $past(section_register[WB_BOOST:WB_ENABLE]);
  endproperty
  a_echo: assert property (p_echo) else $error("echo bits differ");
endmodule // dsi_section

// File: dsi_slave.sv
// dsi_slave: two-wire serial slave serving two supply sections A and B
// assumes: scl/sda come from pins (async), diag flags from analog, open-drain sda
//
// Functional notes
// - device drives ack low for whole pulse
// - no acknowledge while supply lockout active
// - address byte picks section register
// - start, address with rw, data+ack, stop
// - address 00010 plus two select bits
// - register bit layout, limit style to aux
// - write stores data byte in section
// - registers zero, bus ignored during lockout
// - boost and level pick four levels
// - aux bit forces 22 V level
// - tone continuous or follows tone input
// - tone output enable gates tone stage
// - limit style selects pulsed or static
// - threshold test selects 6 or 12 mA
// - read shifts diagnostic byte out msb-first
// - master ack continues read, nack ends
// - read echoes boost, level, enable bits
// - overtemp flag reported, power disabled
// - overload flag reflects protection trip
// - monitor flags set when out of limits
// - bytes eight bits msb-first with ack
`timescale 1ns/1ns
module dsi_slave
  import dsi_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  input  wire logic               supply_lockout_i,
  input  wire logic [1:0]         addr_sel_a_i,
  input  wire logic [1:0]         addr_sel_b_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n_o,
  input  wire logic               tone_in_a_i,
  input  wire logic               tone_in_b_i,
  input  wire dsi_pkg::dsi_diag_s diag_a_i,
  input  wire dsi_pkg::dsi_diag_s diag_b_i,
  output dsi_pkg::dsi_ctrl_s      ctrl_a_o,
  output dsi_pkg::dsi_ctrl_s      ctrl_b_o
);
  import dsi_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK} dsi_state_e;

  // synchronisers: first stage feeds only the second
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] lock_sync;
  logic [1:0] tin_a_sync;
  logic [1:0] tin_b_sync;
  logic [1:0] asel_a_sync;
  logic [1:0] asel_a_meta;
  logic [1:0] asel_b_sync;
  logic [1:0] asel_b_meta;
  logic       scl_d;
  logic       sda_d;

  logic       scl_s;
  logic       sda_s;
  logic       lockout;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  dsi_state_e state;
  dsi_state_e next_state;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic       is_read;
  logic       next_is_read;
  dsi_sec_e   sec;
  dsi_sec_e   next_sec;
  logic       drive_low;
  logic       next_drive_low;
  logic       wr_a;
  logic       wr_b;
  logic       ack_due;
  logic [7:0] rdata_a;
  logic [7:0] rdata_b;

  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign lockout   = lock_sync[1];
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // address match for one section
  function automatic logic addr_hit(input logic [6:0] a, input logic [1:0] sel);
    addr_hit = (a[6:2] == ADDR_FIXED) && (a[1:0] == sel);
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync    <= 2'h3;
      sda_sync    <= 2'h3;
      lock_sync   <= 2'h3;
      tin_a_sync  <= 2'h0;
      tin_b_sync  <= 2'h0;
      asel_a_meta <= 2'h0;
      asel_a_sync <= 2'h0;
      asel_b_meta <= 2'h0;
      asel_b_sync <= 2'h0;
      scl_d       <= 1'b1;
      sda_d       <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_sync    <= {scl_sync[0], scl_i};
      sda_sync    <= {sda_sync[0], sda_i};
      lock_sync   <= {lock_sync[0], supply_lockout_i};
      tin_a_sync  <= {tin_a_sync[0], tone_in_a_i};
      tin_b_sync  <= {tin_b_sync[0], tone_in_b_i};
      asel_a_meta <= addr_sel_a_i;
      asel_a_sync <= asel_a_meta;
      asel_b_meta <= addr_sel_b_i;
      asel_b_sync <= asel_b_meta;
      scl_d       <= scl_s;
      sda_d       <= sda_s;
    end
  end

  always_comb
  begin
    next_state     = state;
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_is_read   = is_read;
    next_sec       = sec;
    next_drive_low = drive_low;
    wr_a           = 1'b0;
    wr_b           = 1'b0;
    ack_due        = 1'b0;
    if (lockout || stop_det)
    begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;
    end
    else if (start_det)
    begin
      next_state     = ST_ADDR;
      next_bit_cnt   = 4'h0;
      next_drive_low = 1'b0;
    end
    else
      unique case (state)
        ST_IDLE: ;
        ST_ADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            next_bit_cnt = 4'h0;
            if (state == ST_ADDR)
            begin
              next_is_read = shift[0];
              if (addr_hit(shift[7:1], asel_a_sync))
              begin
                next_sec = DSI_SEC_A;
                ack_due  = 1'b1;
              end
              else if (addr_hit(shift[7:1], asel_b_sync))
              begin
                next_sec = DSI_SEC_B;
                ack_due  = 1'b1;
              end
            end
            else
            begin
              ack_due = 1'b1;
              wr_a    = (sec == DSI_SEC_A);
              wr_b    = (sec == DSI_SEC_B);
            end
            if (ack_due)
            begin
              next_state     = ST_ACK;
              next_drive_low = 1'b1;
            end
            else
              next_state = ST_IDLE;
          end
        end
        ST_ACK:
          if (scl_fall)
          begin
            if (is_read)
            begin
              next_shift     = (sec == DSI_SEC_A) ? rdata_a : rdata_b;
              next_drive_low = ~next_shift[7];
              next_bit_cnt   = 4'h1;
              next_state     = ST_RDATA;
            end
            else
            begin
              next_drive_low = 1'b0;
              next_state     = ST_WDATA;
            end
          end
        ST_RDATA:
          if (scl_fall)
          begin
            if (bit_cnt == 4'h8)
            begin
              next_drive_low = 1'b0;
              next_state     = ST_RACK;
            end
            else
            begin
              next_shift     = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
              next_bit_cnt   = bit_cnt + 4'h1;
            end
          end
        ST_RACK:
          if (scl_rise)
          begin
            if (!sda_s)
              next_state = ST_ACK;
            else
              next_state = ST_IDLE;
          end
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state     <= ST_IDLE;
      shift     <= 8'h00;
      bit_cnt   <= 4'h0;
      is_read   <= 1'b0;
      sec       <= DSI_SEC_A;
      drive_low <= 1'b0;
    end
    else if (ce_i)
    begin
      state     <= next_state;
      shift     <= next_shift;
      bit_cnt   <= next_bit_cnt;
      is_read   <= next_is_read;
      sec       <= next_sec;
      drive_low <= next_drive_low;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~drive_low;

  dsi_section u_sec_a (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .lockout_i (lockout),
    .wr_i      (wr_a),
    .wdata_i   (shift),
    .tone_in_i (tin_a_sync[1]),
    .diag_i    (diag_a_i),
    .rdata_o   (rdata_a),
    .ctrl_o    (ctrl_a_o)
  );

  dsi_section u_sec_b (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .lockout_i (lockout),
    .wr_i      (wr_b),
    .wdata_i   (shift),
    .tone_in_i (tin_b_sync[1]),
    .diag_i    (diag_b_i),
    .rdata_o   (rdata_b),
    .ctrl_o    (ctrl_b_o)
  );

  // assertions
  property p_lock_no_ack;
    @(posedge clk_i) disable iff (!rst_n_i) ce_i && lockout |=> sda_oe_n_o;
  endproperty
  a_lock_no_ack: assert property (p_lock_no_ack) else $error("ack during lockout");

  property p_ack_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && (state == ST_ADDR || state == ST_WDATA) && next_state == ST_ACK |=> !sda_oe_n_o;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack not driven");

  property p_ack_stable;
    @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_ACK && !sda_oe_n_o && !scl_fall && !stop_det && !start_det && !lockout && ce_i
        |=> !sda_oe_n_o;
  endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("ack released early");

  property p_single_write;
    @(posedge clk_i) disable iff (!rst_n_i) !(wr_a && wr_b);
  endproperty
  a_single_write: assert property (p_single_write) else $error("both sections written");

  property p_read_msb;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && state == ST_ACK && is_read && scl_fall && !lockout && !stop_det && !start_det
        |=> sda_oe_n_o == shift[7];
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read msb wrong");

  property p_nack_ends;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && state == ST_RACK && scl_rise && sda_s && !lockout && !stop_det && !start_det
        |=> state == ST_IDLE ##1 sda_oe_n_o;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("read not ended by nack");

  c_write: cover property (@(posedge clk_i) wr_a);
  c_write_b: cover property (@(posedge clk_i) wr_b);
  c_read: cover property (@(posedge clk_i) state == ST_RACK);
  c_read_more: cover property (@(posedge clk_i) state == ST_RACK ##1 state == ST_ACK);
endmodule // dsi_slave

// File: dsi_host.sv
// dsi_host: behavioural serial bus master driving the slave's two-wire bus
// assumes: open-drain bus resolved outside, pull-up on both lines, clk_i paces bits
`timescale 1ns/1ns
module dsi_host
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // lines released high at idle, clock stands still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one 64 ns clock pulse, data set while scl low, sampled 6 of 8 clocks into high
  task automatic put_bit(input logic b, output logic seen);
    sda_o <= b;
    wait_clk(4);
    scl_o <= 1'b1;
    wait_clk(6);
    seen = sda_i;
    wait_clk(2);
    scl_o <= 1'b0;
    wait_clk(4);
  endtask

  task automatic start_cond();
    sda_o <= 1'b1;
    scl_o <= 1'b1;
    wait_clk(4);
    sda_o <= 1'b0;
    wait_clk(4);
    scl_o <= 1'b0;
    wait_clk(4);
  endtask

  // always sent, also after a missing acknowledge
  task automatic stop_cond();
    sda_o <= 1'b0;
    wait_clk(4);
    scl_o <= 1'b1;
    wait_clk(4);
    sda_o <= 1'b1;
    wait_clk(8);
  endtask

  // eight bits msb first, then ninth pulse; mack 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] got,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], got[i]);
    put_bit(mack, s);
    ack = ~s;
  endtask
endmodule // dsi_host

// File: dual_section_i2c_control_slave_tb_top.sv
// testbench: drives the dual-section slave through the bus master model
// assumes: dsi_slave as device, dsi_host as master, wired-and open-drain data line
`timescale 1ns/1ns
module dual_section_i2c_control_slave_tb_top;
  import dsi_pkg::*;
  logic            clk_i;
  logic            rst_n_i;
  logic            lockout;
  logic            tone_a;
  dsi_diag_s       diag_a;
  logic            scl;
  logic            host_sda;
  logic            dev_sda;
  logic            dev_oe_n;
  wire logic       sda;
  dsi_ctrl_s       ctrl_a;
  dsi_ctrl_s       ctrl_b;
  int              fail_count = 0;
  int              compares   = 0;
  logic [7:0]      wtab [6]   = '{8'h04, 8'h0C, 8'h14, 8'h1C, 8'h1F, 8'h1B};
  logic [2:0]      ltab [6]   = '{LVL_13V4, LVL_18V5, LVL_14V4, LVL_19V5, LVL_22V, LVL_OFF};

  assign sda = host_sda & (dev_oe_n | dev_sda);

  dsi_slave i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .supply_lockout_i(lockout),
    .addr_sel_a_i(2'b01), .addr_sel_b_i(2'b10), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
    .sda_oe_n_o(dev_oe_n), .tone_in_a_i(tone_a), .tone_in_b_i(1'b0), .diag_a_i(diag_a),
    .diag_b_i(5'h00), .ctrl_a_o(ctrl_a), .ctrl_b_o(ctrl_b));

  dsi_host i_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // write one byte to a section, comparing the address ack and, only when it is given, the data ack
  task automatic wr(input logic [6:0] adr, input logic [7:0] d, input logic exp_ack);
    logic [7:0] g;
    logic       a;
    i_host.start_cond();
    i_host.xfer({adr, 1'b0}, 1'b1, g, a);
    check({7'h00, a}, {7'h00, exp_ack}, "address ack");
    if (a)
    begin
      i_host.xfer(d, 1'b1, g, a);
      check({7'h00, a}, 8'h01, "data ack");
    end
    i_host.stop_cond();
  endtask

  // read two bytes: master ack after first, not-ack after second
  task automatic rd(input logic [6:0] adr, input logic [7:0] exp);
    logic [7:0] g;
    logic       a;
    i_host.start_cond();
    i_host.xfer({adr, 1'b1}, 1'b1, g, a);
    check({7'h00, a}, 8'h01, "read address ack");
    i_host.xfer(8'hFF, 1'b0, g, a);
    check(g, exp, "read byte 0");
    i_host.xfer(8'hFF, 1'b1, g, a);
    check(g, exp, "read byte 1");
    i_host.stop_cond();
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  initial
  begin
    rst_n_i = 1'b0;
    lockout = 1'b0;
    tone_a  = 1'b0;
    diag_a  = 5'h00;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({7'h00, |ctrl_a}, 8'h00, "ctrl a at reset");
    rd(7'h0A, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(7'h09, wtab[i], 1'b1);
      check({5'h00, ctrl_a.level}, {5'h00, ltab[i]}, "level");
      check({7'h00, ctrl_a.power_on}, {7'h00, wtab[i][2]}, "power on");
    end
    wr(7'h09, 8'hE6, 1'b1);
    check({7'h00, ctrl_a.static_limit}, 8'h01, "static limit");
    check({7'h00, ctrl_a.thresh_12ma}, 8'h01, "threshold");
    check({7'h00, ctrl_a.tone_active}, 8'h01, "tone continuous");
    check({7'h00, ctrl_a.tone_output_stage}, 8'h01, "tone stage");
    check({7'h00, ctrl_a.receive_output}, 8'h01, "receive output");
    wr(7'h0A, 8'h14, 1'b1);
    check({5'h00, ctrl_b.level}, {5'h00, LVL_14V4}, "section b level");
    check({5'h00, ctrl_a.level}, {5'h00, LVL_13V4}, "section a kept");
    wr(7'h09, 8'h24, 1'b1);
    check({7'h00, ctrl_a.tone_output_stage}, 8'h00, "tone stage off");
    check({7'h00, ctrl_a.tone_active}, 8'h00, "tone gated off");
    check({7'h00, ctrl_a.static_limit}, 8'h00, "pulsed limit");
    wr(7'h09, 8'h44, 1'b1);
    tone_a <= 1'b1;
    repeat (8) @(posedge clk_i);
    check({7'h00, ctrl_a.tone_active}, 8'h01, "tone follows pin");
    tone_a <= 1'b0;
    repeat (8) @(posedge clk_i);
    check({7'h00, ctrl_a.tone_active}, 8'h00, "tone pin low");
    diag_a <= 5'b10101;
    rd(7'h09, 8'hA5);
    diag_a <= 5'b01010;
    rd(7'h09, 8'h46);
    check({7'h00, ctrl_a.power_on}, 8'h00, "overtemp power off");
    diag_a <= 5'h00;
    wr(7'h0B, 8'h04, 1'b0);
    wr(7'h08, 8'h04, 1'b0);
    lockout <= 1'b1;
    repeat (8) @(posedge clk_i);
    check({7'h00, |ctrl_a}, 8'h00, "ctrl a in lockout");
    wr(7'h09, 8'h04, 1'b0);
    lockout <= 1'b0;
    repeat (8) @(posedge clk_i);
    check({7'h00, |ctrl_a}, 8'h00, "ctrl a after lockout");
    rd(7'h09, 8'h00);
    final_report();
  end
endmodule // dual_section_i2c_control_slave_tb_top
